// ---- include/int_trap_pkg.sv ----
`default_nettype none
package int_trap_pkg;
  localparam int NODES = 46;
  localparam int DEDIC = 40;
  localparam int ERU_CH = 4;
  localparam int SHARED = 2;
  localparam int SHARED_SRC = 4;
  localparam int CHANS = 8;
  localparam int ESR_PINS = 3;
  localparam int HW_TRAPS = 6;
  localparam int TRAPS = 8;
  localparam int PRIO_W = 4;
  localparam int CH_W = 3;
  localparam int SEL_W = 2;
  localparam int CNT_W = 8;
  localparam int PTR_W = 16;
  localparam int VEC_W = 7;
  localparam int NODE_W = 6;
  localparam int TRAP_W = 3;
  localparam int LAT_W = 4;
  localparam int ADDR_W = 12;
  localparam int WORD_LSB = 2;
  localparam int PEC_SEL_LSB = 3;
  localparam int PEC_PTR_BIT = 2;
  localparam logic [ADDR_W-1:0] NODE_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] NODE_END = 12'h0B8;
  localparam logic [ADDR_W-1:0] PEC_BASE = 12'h100;
  localparam logic [ADDR_W-1:0] ERU_CFG_ADDR = 12'h180;
  localparam logic [ADDR_W-1:0] SRC_SEL_ADDR = 12'h184;
  localparam logic [ADDR_W-1:0] TRAP_FLAG_ADDR = 12'h188;
  localparam logic [ADDR_W-1:0] SYS_CFG_ADDR = 12'h18C;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h190;
  // node control fields
  localparam int NC_REQ = 0;
  localparam int NC_EN = 1;
  localparam int NC_PRIO = 2;
  localparam int NC_PEC_EN = 6;
  localparam int NC_PEC_CH = 7;
  // transfer channel fields
  localparam int PC_CNT = 0;
  localparam int PC_CONT = 8;
  localparam int PC_WORD = 9;
  localparam int PC_INC_SRC = 10;
  localparam int PC_INC_DST = 11;
  localparam int PP_SRC = 0;
  localparam int PP_DST = 16;
  // router fields
  localparam int EC_EDGE = 0;
  localparam int EC_ROUTE = 8;
  localparam int EC_GATE = 16;
  localparam int EC_PAT = 24;
  localparam int EC_MASK = 28;
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;
  localparam logic [1:0] GATE_ALWAYS = 2'h1;
  localparam logic [1:0] GATE_MATCH = 2'h2;
  localparam logic [1:0] GATE_MISS = 2'h3;
  localparam int ST_VEC_LSB = 3;
  localparam int TRAP_SR0 = 0;
  localparam int TRAP_SR1 = 1;
  localparam int LAT_JC_CYC = 7;
  localparam int LAT_NOJC_CYC = 11;
  localparam logic [LAT_W-1:0] LAT_JC_LOAD = LAT_W'(LAT_JC_CYC - 1);
  localparam logic [LAT_W-1:0] LAT_NOJC_LOAD = LAT_W'(LAT_NOJC_CYC - 1);
  localparam logic [VEC_W-1:0] TRAP_VEC_BASE = 7'h00;
  localparam logic [VEC_W-1:0] NODE_VEC_BASE = 7'h10;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LAT = 2'b01,
    ST_VEC = 2'b11,
    ST_TRAP = 2'b10
  } svc_state_e;
endpackage : int_trap_pkg
`default_nettype wire

// ---- hdl/int_trap_sys.sv ----
// Summary of operation
// - each node routes to vectored service or a transfer channel
// - vectored service presents the node vector until the CPU acknowledges
// - transfer takes one cycle and produces no vector
// - transfer moves byte or word, then bumps source and/or destination
// - channel counter decrements per transfer unless continuous
// - counter at zero turns the request into a vectored service
// - eight independent transfer channels
// - response latency 7 clocks with jump cache, 11 without
// - 46 nodes, each with request flag, enable and priority
// - shared nodes take their source from a select register
// - router: 4 inputs, edge logic, routing matrix, 4 gating units
// - each input detects rising, falling or both edges
// - gating unit passes events on pattern match or miss
// - hardware trap branches to its own vector like an interrupt
// - each trap sets its own flag bit
// - trap preempts unless a higher priority trap runs
// - during a trap service interrupts and transfers wait
// - three service request pins make two system request traps
// - software trap number starts that vector's service
// - software writing the request flag raises a request
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`default_nettype none
module int_trap_sys
  import int_trap_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [ADDR_W-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [ADDR_W-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  input wire logic [DEDIC-1:0] node_req_i,
  input wire logic [SHARED_SRC-1:0] shared_src_i,
  input wire logic [ERU_CH-1:0] eru_in_i,
  input wire logic [ESR_PINS-1:0] esr_pin_i,
  input wire logic [HW_TRAPS-1:0] hw_trap_i,
  output logic int_req_o,
  output logic [VEC_W-1:0] vector_o,
  input wire logic int_ack_i,
  input wire logic trap_ret_i,
  input wire logic sw_trap_i,
  input wire logic [VEC_W-1:0] sw_trap_num_i,
  output logic sw_trap_ready_o,
  output logic pec_valid_o,
  output logic [CH_W-1:0] pec_chan_o,
  output logic pec_word_o,
  output logic [PTR_W-1:0] pec_src_o,
  output logic [PTR_W-1:0] pec_dst_o
);
  typedef struct packed {
    logic [NODES-1:0] req;
    logic [NODES-1:0] en;
    logic [NODES-1:0][PRIO_W-1:0] prio;
    logic [NODES-1:0] pec_en;
    logic [NODES-1:0][CH_W-1:0] pec_ch;
    logic [CHANS-1:0][CNT_W-1:0] cnt;
    logic [CHANS-1:0] cont, word, inc_src, inc_dst;
    logic [CHANS-1:0][PTR_W-1:0] src, dst;
    logic [ERU_CH-1:0][1:0] edge_cfg, route, gate;
    logic [ERU_CH-1:0] pat, mask, eru_prev;
    logic [SHARED-1:0][SEL_W-1:0] sel;
    logic [ESR_PINS-1:0] esr_prev;
    logic [TRAPS-1:0] trap_flag_register, tpend;
    logic jc;
    svc_state_e st;
    logic [LAT_W-1:0] lat;
    logic [VEC_W-1:0] vec;
    logic is_trap;
    logic [TRAP_W-1:0] cur_trap;
    logic pec_valid, pec_word;
    logic [CH_W-1:0] pec_chan;
    logic [PTR_W-1:0] pec_src, pec_dst;
    logic aw_h, w_h, bvalid, rvalid;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
  } state_s;

  state_s q, d;
  logic [ERU_CH-1:0] eru_evt, ogu_out;
  logic pat_hit;
  logic [ESR_PINS-1:0] esr_rise;
  logic [TRAPS-1:0] trap_evt;
  logic [NODES-1:0] node_set;
  logic gv, tv, trap_go, node_grant, pec_fire, zero_hit, wr_fire, in_lat;
  logic [NODE_W-1:0] g, nidx;
  logic [TRAP_W-1:0] tk;
  logic [CH_W-1:0] pch, wch;
  logic [PRIO_W-1:0] best_p;
  logic [LAT_W-1:0] lat_load;
  logic [ADDR_W-1:0] wa;
  logic [31:0] wd, wm, nv;
  logic [CNT_W-1:0] cnt_sel;

  function automatic logic mapped(logic [ADDR_W-1:0] a);
    return (a < NODE_END) || (a >= PEC_BASE && a <= STATUS_ADDR);
  endfunction : mapped

  function automatic logic [PTR_W-1:0] ptr_step(logic [PTR_W-1:0] p,
                                                logic inc, logic w);
    logic [PTR_W-1:0] step;
    step = w ? 16'h0002 : 16'h0001;
    return inc ? p + step : p;
  endfunction : ptr_step

  function automatic logic [31:0] rd_word(state_s s, logic [ADDR_W-1:0] a);
    logic [31:0] r;
    logic [NODE_W-1:0] n;
    logic [CH_W-1:0] c;
    r = '0;
    n = NODE_W'(a >> WORD_LSB);
    c = CH_W'(a >> PEC_SEL_LSB);
    if (a < NODE_END) begin
      r[NC_REQ] = s.req[n];
      r[NC_EN] = s.en[n];
      r[NC_PRIO +: PRIO_W] = s.prio[n];
      r[NC_PEC_EN] = s.pec_en[n];
      r[NC_PEC_CH +: CH_W] = s.pec_ch[n];
    end else if (a >= PEC_BASE && a < ERU_CFG_ADDR) begin
      if (a[PEC_PTR_BIT]) begin
        r[PP_SRC +: PTR_W] = s.src[c];
        r[PP_DST +: PTR_W] = s.dst[c];
      end else begin
        r[PC_CNT +: CNT_W] = s.cnt[c];
        r[PC_CONT] = s.cont[c];
        r[PC_WORD] = s.word[c];
        r[PC_INC_SRC] = s.inc_src[c];
        r[PC_INC_DST] = s.inc_dst[c];
      end
    end else begin
      unique case (a)
        ERU_CFG_ADDR: r = {s.mask, s.pat, 8'(s.gate), 8'(s.route),
                           8'(s.edge_cfg)};
        SRC_SEL_ADDR: r[SHARED*SEL_W-1:0] = s.sel;
        TRAP_FLAG_ADDR: r[TRAPS-1:0] = s.trap_flag_register;
        SYS_CFG_ADDR: r[0] = s.jc;
        STATUS_ADDR: r[ST_VEC_LSB+VEC_W-1:0] = {s.vec, s.is_trap, s.st};
        default: r = '0;
      endcase
    end
    return r;
  endfunction : rd_word

  assign wa = q.aw_h ? q.awaddr : awaddr_i;
  assign wd = q.w_h ? q.wdata : wdata_i;
  assign nidx = NODE_W'(wa >> WORD_LSB);
  assign wch = CH_W'(wa >> PEC_SEL_LSB);
  assign pch = q.pec_ch[g];
  assign cnt_sel = q.cnt[pch];
  assign lat_load = q.jc ? LAT_JC_LOAD : LAT_NOJC_LOAD;
  assign trap_go = tv && (q.st == ST_IDLE ||
                          (q.st == ST_TRAP && tk < q.cur_trap));
  assign node_grant = q.st == ST_IDLE && !tv && !sw_trap_i && gv;
  assign in_lat = q.st == ST_LAT;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wm[8*b +: 8] = {8{q.w_h ? q.wstrb[b] : wstrb_i[b]}};
    end
    nv = (rd_word(q, wa) & ~wm) | (wd & wm);
  end

  // node arbitration; ties go to the lower node number
  always_comb begin
    gv = 1'b0;
    g = '0;
    best_p = '0;
    for (int n = 0; n < NODES; n++) begin
      if (q.req[n] && q.en[n] && q.prio[n] > best_p) begin
        gv = 1'b1;
        g = NODE_W'(n);
        best_p = q.prio[n];
      end
    end
    tv = |q.tpend;
    tk = '0;
    for (int t = TRAPS - 1; t >= 0; t--) begin
      if (q.tpend[t]) begin
        tk = TRAP_W'(t);
      end
    end
  end

  always_comb begin
    d = q;
    d.pec_valid = 1'b0;
    pec_fire = 1'b0;
    zero_hit = 1'b0;
    for (int i = 0; i < ERU_CH; i++) begin
      eru_evt[i] = (q.edge_cfg[i][EDGE_RISE_BIT] & eru_in_i[i] &
                    ~q.eru_prev[i]) |
                   (q.edge_cfg[i][EDGE_FALL_BIT] & ~eru_in_i[i] &
                    q.eru_prev[i]);
    end
    pat_hit = ((eru_in_i ^ q.pat) & q.mask) == '0;
    for (int j = 0; j < ERU_CH; j++) begin
      ogu_out[j] = eru_evt[q.route[j]] &
                   ((q.gate[j] == GATE_ALWAYS) |
                    (q.gate[j] == GATE_MATCH & pat_hit) |
                    (q.gate[j] == GATE_MISS & ~pat_hit));
    end
    d.eru_prev = eru_in_i;
    esr_rise = esr_pin_i & ~q.esr_prev;
    d.esr_prev = esr_pin_i;
    trap_evt = {hw_trap_i, |esr_rise[ESR_PINS-1:TRAP_SR1],
                esr_rise[TRAP_SR0]};
    node_set = {{SHARED{1'b0}}, ogu_out, node_req_i};
    for (int s = 0; s < SHARED; s++) begin
      node_set[DEDIC+ERU_CH+s] = shared_src_i[q.sel[s]];
    end
    // register bus: address and data may arrive in either order
    if (awvalid_i && awready_o) begin
      d.aw_h = 1'b1;
      d.awaddr = awaddr_i;
    end
    if (wvalid_i && wready_o) begin
      d.w_h = 1'b1;
      d.wdata = wdata_i;
      d.wstrb = wstrb_i;
    end
    wr_fire = (q.aw_h | (awvalid_i & awready_o)) &
              (q.w_h | (wvalid_i & wready_o));
    if (q.bvalid && bready_i) begin
      d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      d.aw_h = 1'b0;
      d.w_h = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = mapped(wa) ? RESP_OKAY : RESP_SLVERR;
      if (wa < NODE_END) begin
        d.req[nidx] = nv[NC_REQ];
        d.en[nidx] = nv[NC_EN];
        d.prio[nidx] = nv[NC_PRIO +: PRIO_W];
        d.pec_en[nidx] = nv[NC_PEC_EN];
        d.pec_ch[nidx] = nv[NC_PEC_CH +: CH_W];
      end else if (wa >= PEC_BASE && wa < ERU_CFG_ADDR) begin
        if (wa[PEC_PTR_BIT]) begin
          d.src[wch] = nv[PP_SRC +: PTR_W];
          d.dst[wch] = nv[PP_DST +: PTR_W];
        end else begin
          d.cnt[wch] = nv[PC_CNT +: CNT_W];
          d.cont[wch] = nv[PC_CONT];
          d.word[wch] = nv[PC_WORD];
          d.inc_src[wch] = nv[PC_INC_SRC];
          d.inc_dst[wch] = nv[PC_INC_DST];
        end
      end else begin
        unique case (wa)
          ERU_CFG_ADDR: begin
            d.edge_cfg = nv[EC_EDGE +: 2*ERU_CH];
            d.route = nv[EC_ROUTE +: 2*ERU_CH];
            d.gate = nv[EC_GATE +: 2*ERU_CH];
            d.pat = nv[EC_PAT +: ERU_CH];
            d.mask = nv[EC_MASK +: ERU_CH];
          end
          SRC_SEL_ADDR: d.sel = nv[SHARED*SEL_W-1:0];
          TRAP_FLAG_ADDR: d.trap_flag_register = q.trap_flag_register & ~(wd[TRAPS-1:0] & wm[TRAPS-1:0]);
          SYS_CFG_ADDR: d.jc = nv[0];
          default: d.jc = q.jc;
        endcase
      end
    end
    if (q.rvalid && rready_i) begin
      d.rvalid = 1'b0;
    end
    if (arvalid_i && arready_o) begin
      d.rvalid = 1'b1;
      d.rdata = rd_word(q, araddr_i);
      d.rresp = mapped(araddr_i) ? RESP_OKAY : RESP_SLVERR;
    end
    // service sequencing
    if (trap_go) begin
      d.tpend[tk] = 1'b0;
      d.cur_trap = tk;
      d.is_trap = 1'b1;
      d.vec = TRAP_VEC_BASE + VEC_W'(tk);
      d.st = ST_LAT;
      d.lat = lat_load;
    end else begin
      unique case (q.st)
        ST_IDLE: begin
          if (sw_trap_i) begin
            d.vec = sw_trap_num_i;
            d.is_trap = 1'b0;
            d.st = ST_LAT;
            d.lat = lat_load;
          end else if (gv) begin
            d.req[g] = 1'b0;
            if (q.pec_en[g] && (q.cont[pch] || q.cnt[pch] != '0)) begin
              pec_fire = 1'b1;
              d.pec_valid = 1'b1;
              d.pec_chan = pch;
              d.pec_word = q.word[pch];
              d.pec_src = q.src[pch];
              d.pec_dst = q.dst[pch];
              d.src[pch] = ptr_step(q.src[pch], q.inc_src[pch],
                                    q.word[pch]);
              d.dst[pch] = ptr_step(q.dst[pch], q.inc_dst[pch],
                                    q.word[pch]);
              if (!q.cont[pch]) begin
                d.cnt[pch] = q.cnt[pch] - CNT_ONE;
              end
            end else begin
              zero_hit = q.pec_en[g];
              d.vec = NODE_VEC_BASE + VEC_W'(g);
              d.is_trap = 1'b0;
              d.st = ST_LAT;
              d.lat = lat_load;
            end
          end
        end
        ST_LAT: begin
          if (q.lat == '0) begin
            d.st = ST_VEC;
          end else begin
            d.lat = q.lat - LAT_W'(1);
          end
        end
        ST_VEC: begin
          if (int_ack_i) begin
            d.st = q.is_trap ? ST_TRAP : ST_IDLE;
          end
        end
        ST_TRAP: begin
          if (trap_ret_i) begin
            d.st = ST_IDLE;
          end
        end
      endcase
    end
    // late sets win over same-cycle clears
    d.req = d.req | node_set;
    d.trap_flag_register = d.trap_flag_register | trap_evt;
    d.tpend = d.tpend | trap_evt;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign awready_o = !q.aw_h && !q.bvalid;
  assign wready_o = !q.w_h && !q.bvalid;
  assign bvalid_o = q.bvalid;
  assign bresp_o = q.bresp;
  assign arready_o = !q.rvalid;
  assign rvalid_o = q.rvalid;
  assign rdata_o = q.rdata;
  assign rresp_o = q.rresp;
  assign int_req_o = q.st == ST_VEC;
  assign vector_o = q.vec;
  assign sw_trap_ready_o = q.st == ST_IDLE && !tv;
  assign pec_valid_o = q.pec_valid;
  assign pec_chan_o = q.pec_chan;
  assign pec_word_o = q.pec_word;
  assign pec_src_o = q.pec_src;
  assign pec_dst_o = q.pec_dst;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_pec_single;
    pec_valid_o |=> !pec_valid_o && !int_req_o;
  endproperty
  a_pec_single: assert property (p_pec_single)
    else $error("transfer strobe longer than one cycle");
  property p_pec_count;
    pec_fire && !q.cont[pch] |=> q.cnt[$past(pch)] == $past(cnt_sel) - CNT_ONE;
  endproperty
  a_pec_count: assert property (p_pec_count)
    else $error("transfer counter not decremented");
  property p_zero_vec;
    zero_hit |=> in_lat && vector_o == NODE_VEC_BASE + VEC_W'($past(g));
  endproperty
  a_zero_vec: assert property (p_zero_vec)
    else $error("empty channel did not raise node vector");
  property p_lat_jc;
    $rose(in_lat) && $past(q.jc) |-> in_lat[*7] ##1 int_req_o;
  endproperty
  a_lat_jc: assert property (p_lat_jc)
    else $error("latency with jump cache not 7");
  property p_lat_nojc;
    $rose(in_lat) && !$past(q.jc) |-> ##10 !int_req_o ##1 int_req_o;
  endproperty
  a_lat_nojc: assert property (p_lat_nojc)
    else $error("latency without jump cache not 11");
  property p_vec_hold;
    int_req_o && !int_ack_i |=> int_req_o && $stable(vector_o);
  endproperty
  a_vec_hold: assert property (p_vec_hold)
    else $error("vector dropped before acknowledge");
  property p_grant_clear;
    node_grant && !node_set[g] && !wr_fire |=> !q.req[$past(g)];
  endproperty
  a_grant_clear: assert property (p_grant_clear)
    else $error("granted request flag not cleared");
  property p_trap_flag;
    trap_evt != '0 |=> (q.trap_flag_register & $past(trap_evt)) == $past(trap_evt);
  endproperty
  a_trap_flag: assert property (p_trap_flag)
    else $error("trap flag not set");
  property p_trap_hold;
    q.st == ST_TRAP |=> !pec_valid_o && (!in_lat || q.is_trap);
  endproperty
  a_trap_hold: assert property (p_trap_hold)
    else $error("service started inside trap");
  property p_sw_trap;
    sw_trap_i && sw_trap_ready_o |=> in_lat && vector_o == $past(sw_trap_num_i);
  endproperty
  a_sw_trap: assert property (p_sw_trap)
    else $error("software trap vector wrong");
  property p_esr_sr1;
    esr_rise[ESR_PINS-1:TRAP_SR1] != '0 |=> q.trap_flag_register[TRAP_SR1];
  endproperty
  a_esr_sr1: assert property (p_esr_sr1)
    else $error("pin request did not reach trap one");
  c_pec: cover property (pec_fire ##1 pec_valid_o);
  c_zero: cover property (zero_hit ##[1:20] int_ack_i);
  c_preempt: cover property (q.st == ST_TRAP && trap_go);
  c_sw: cover property (sw_trap_i && sw_trap_ready_o);
endmodule : int_trap_sys
`default_nettype wire

// ---- tb/cpu_model.sv ----
`default_nettype none
module cpu_model
  import int_trap_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic int_req_i,
  input wire logic [VEC_W-1:0] vector_i,
  input wire logic [3:0] ack_dly_i,
  input wire logic [7:0] ret_dly_i,
  output logic int_ack_o,
  output logic trap_ret_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  logic [7:0] ret_q;
  logic busy_q;
  // ack is a one-cycle pulse, taken at the edge that sees it with the request
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_q <= '0;
      ret_q <= '0;
      busy_q <= 1'b0;
      int_ack_o <= 1'b0;
      trap_ret_o <= 1'b0;
    end else begin
      int_ack_o <= 1'b0;
      trap_ret_o <= 1'b0;
      if (busy_q) begin
        if (ret_q == 8'h00) begin
          trap_ret_o <= 1'b1;
          busy_q <= 1'b0;
        end else begin
          ret_q <= ret_q - 8'h01;
        end
      end
      if (int_ack_o && int_req_i) begin
        wait_q <= '0;
        // only trap vectors run as a trap service that needs a return
        if (vector_i < VEC_W'(TRAPS)) begin
          busy_q <= 1'b1;
          ret_q <= ret_dly_i;
        end
      end else if (int_req_i) begin
        if (wait_q == ack_dly_i) begin
          int_ack_o <= 1'b1;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule : cpu_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import int_trap_pkg::*;
  localparam int LIMIT = 30000;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [ADDR_W-1:0] awaddr_i = '0;
  logic awvalid_i = 1'b0;
  logic [31:0] wdata_i = '0;
  logic [3:0] wstrb_i = 4'hF;
  logic wvalid_i = 1'b0;
  logic bready_i = 1'b0;
  logic [ADDR_W-1:0] araddr_i = '0;
  logic arvalid_i = 1'b0;
  logic rready_i = 1'b0;
  logic [DEDIC-1:0] node_req_i = '0;
  logic [SHARED_SRC-1:0] shared_src_i = '0;
  logic [ERU_CH-1:0] eru_in_i = '0;
  logic [ESR_PINS-1:0] esr_pin_i = '0;
  logic [HW_TRAPS-1:0] hw_trap_i = '0;
  logic sw_trap_i = 1'b0;
  logic [VEC_W-1:0] sw_trap_num_i = '0;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic [1:0] bresp_o, rresp_o, rsp;
  logic [31:0] rdata_o, rdv;
  logic int_req_o, int_ack_i, trap_ret_i, sw_trap_ready_o;
  logic [VEC_W-1:0] vector_o, v;
  logic pec_valid_o, pec_word_o, pw, p1, iq, h;
  logic [CH_W-1:0] pec_chan_o, pc;
  logic [PTR_W-1:0] pec_src_o, pec_dst_o;
  logic [3:0] ack_dly = 4'h0;
  logic [7:0] ret_dly = 8'd40;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int n;

  int_trap_sys uut (.ref_clk_i, .arst_n_i, .awaddr_i, .awvalid_i, .awready_o,
    .wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i,
    .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o,
    .rready_i, .node_req_i, .shared_src_i, .eru_in_i, .esr_pin_i, .hw_trap_i,
    .int_req_o, .vector_o, .int_ack_i, .trap_ret_i, .sw_trap_i,
    .sw_trap_num_i, .sw_trap_ready_o, .pec_valid_o, .pec_chan_o, .pec_word_o,
    .pec_src_o, .pec_dst_o);

  cpu_model cpu (.ref_clk_i, .arst_n_i, .int_req_i(int_req_o),
    .vector_i(vector_o), .ack_dly_i(ack_dly), .ret_dly_i(ret_dly),
    .int_ack_o(int_ack_i), .trap_ret_o(trap_ret_i));

  always #2.5 ref_clk_i = ~ref_clk_i;

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // a hang anywhere ends in the same closing report
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_fail++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [ADDR_W-1:0] na(input int k);
    return NODE_BASE + ADDR_W'(4 * k);
  endfunction : na

  function automatic logic [ADDR_W-1:0] pa(input int c);
    return PEC_BASE + ADDR_W'(8 * c);
  endfunction : pa

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk_i);
      if (!aw_ok && awready_o === 1'b1) begin
        aw_ok = 1'b1;
        awvalid_i <= 1'b0;
      end
      if (!w_ok && wready_o === 1'b1) begin
        w_ok = 1'b1;
        wvalid_i <= 1'b0;
      end
    end
    do @(posedge ref_clk_i); while (bvalid_o !== 1'b1);
    rsp = bresp_o;
    bready_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    do @(posedge ref_clk_i); while (arready_o !== 1'b1);
    arvalid_i <= 1'b0;
    do @(posedge ref_clk_i); while (rvalid_o !== 1'b1);
    rdv = rdata_o;
    rsp = rresp_o;
    rready_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : rd

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    rd(a);
    chk(rdv, e);
  endtask : rdc

  task automatic pls(input logic [DEDIC-1:0] m);
    node_req_i <= m;
    @(posedge ref_clk_i);
    node_req_i <= '0;
  endtask : pls

  task automatic trap(input logic [HW_TRAPS-1:0] m);
    hw_trap_i <= m;
    @(posedge ref_clk_i);
    hw_trap_i <= '0;
  endtask : trap

  // n counts edges from the one that latches the request flag
  task automatic wait_vec(output logic [VEC_W-1:0] vv, output int k);
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (int_req_o !== 1'b1);
    vv = vector_o;
    do @(posedge ref_clk_i); while (int_req_o === 1'b1);
  endtask : wait_vec

  task automatic wait_pec(output logic [CH_W-1:0] c, output logic w,
                          output logic again, output logic irq);
    do @(posedge ref_clk_i); while (pec_valid_o !== 1'b1);
    c = pec_chan_o;
    w = pec_word_o;
    @(posedge ref_clk_i);
    again = pec_valid_o;
    irq = int_req_o;
  endtask : wait_pec

  task automatic quiet(input int k, output logic hit);
    hit = 1'b0;
    repeat (k) begin
      @(posedge ref_clk_i);
      if (int_req_o !== 1'b0) hit = 1'b1;
    end
  endtask : quiet

  initial begin
    repeat (10) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    rdc(SYS_CFG_ADDR, 32'h0);
    rdc(na(5), 32'h0);
    rd(12'h1FC);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(12'h1FC, 32'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(na(5), 32'hE);
    chk(32'(rsp), 32'(RESP_OKAY));
    rdc(na(5), 32'hE);
    pls(40'h20);
    wait_vec(v, n);
    chk(32'(v), 32'h15);
    chk(n, LAT_NOJC_CYC + 2);
    wr(SYS_CFG_ADDR, 32'h1);
    ack_dly <= 4'h5;
    pls(40'h20);
    wait_vec(v, n);
    chk(n, LAT_JC_CYC + 2);
    wr(na(7), 32'h26);
    pls(40'hA0);
    wait_vec(v, n);
    chk(32'(v), 32'h17);
    wait_vec(v, n);
    chk(32'(v), 32'h15);
    wr(na(5), 32'hF);
    wait_vec(v, n);
    chk(32'(v), 32'h15);
    rdc(na(5), 32'hE);
    for (int c = 0; c < CHANS; c++) begin
      wr(pa(c), 32'h401);
      wr(pa(c) + 12'h4, 32'h2000_1000);
      wr(na(c), 32'h46 | (c << 7));
      pls(DEDIC'(1) << c);
      wait_pec(pc, pw, p1, iq);
      chk(32'(pc), c);
      chk({p1, iq, pw}, 0);
      chk({pec_dst_o, pec_src_o}, 32'h2000_1000);
      rdc(pa(c) + 12'h4, 32'h2000_1001);
      rdc(pa(c), 32'h400);
      pls(DEDIC'(1) << c);
      wait_vec(v, n);
      chk(32'(v), 32'(NODE_VEC_BASE) + c);
    end
    wr(pa(2), 32'hF03);
    wr(pa(2) + 12'h4, 32'h2000_1000);
    pls(40'h4);
    wait_pec(pc, pw, p1, iq);
    chk(pw, 1);
    chk({pec_dst_o, pec_src_o}, 32'h2000_1000);
    rdc(pa(2) + 12'h4, 32'h2002_1002);
    rdc(pa(2), 32'hF03);
    wr(na(9), 32'hA);
    trap(6'h1);
    wait_vec(v, n);
    chk(32'(v), 32'h2);
    pls(40'h200);
    quiet(20, h);
    chk(h, 0);
    wait_vec(v, n);
    chk(32'(v), 32'h19);
    rdc(TRAP_FLAG_ADDR, 32'h4);
    wr(TRAP_FLAG_ADDR, 32'h4);
    rdc(TRAP_FLAG_ADDR, 32'h0);
    trap(6'h1);
    wait_vec(v, n);
    trap(6'h2);
    quiet(20, h);
    chk(h, 0);
    wait_vec(v, n);
    chk(32'(v), 32'h3);
    esr_pin_i <= 3'h1;
    wait_vec(v, n);
    chk(32'(v), TRAP_SR0);
    esr_pin_i <= 3'h5;
    wait_vec(v, n);
    chk(32'(v), TRAP_SR1);
    esr_pin_i <= 3'h0;
    sw_trap_num_i <= 7'h5;
    sw_trap_i <= 1'b1;
    do @(posedge ref_clk_i); while (sw_trap_ready_o !== 1'b1);
    sw_trap_i <= 1'b0;
    wait_vec(v, n);
    chk(32'(v), 32'h5);
    wr(na(40), 32'hA);
    wr(ERU_CFG_ADDR, 32'h0001_0001);
    eru_in_i <= 4'h1;
    wait_vec(v, n);
    chk(32'(v), 32'h38);
    eru_in_i <= 4'h0;
    quiet(20, h);
    chk(h, 0);
    wr(ERU_CFG_ADDR, 32'h0001_0002);
    eru_in_i <= 4'h1;
    quiet(20, h);
    chk(h, 0);
    eru_in_i <= 4'h0;
    wait_vec(v, n);
    chk(32'(v), 32'h38);
    wr(ERU_CFG_ADDR, 32'h2202_0001);
    eru_in_i <= 4'h1;
    quiet(20, h);
    chk(h, 0);
    eru_in_i <= 4'h2;
    @(posedge ref_clk_i);
    eru_in_i <= 4'h3;
    wait_vec(v, n);
    chk(32'(v), 32'h38);
    wr(SRC_SEL_ADDR, 32'h2);
    wr(na(44), 32'hA);
    shared_src_i <= 4'h2;
    @(posedge ref_clk_i);
    shared_src_i <= 4'h0;
    quiet(20, h);
    chk(h, 0);
    shared_src_i <= 4'h4;
    @(posedge ref_clk_i);
    shared_src_i <= 4'h0;
    wait_vec(v, n);
    chk(32'(v), 32'h3C);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
